// File: wid_pkg.sv
// Package for the wake input detector: register map, reset values,
// operating modes and filter timing.
// Assumes a 125 MHz system clock and 32-bit AHB-Lite register access.
package wid_pkg;

    // ------------------------------------------------------------------
    // Register map, byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] WAKE_ENABLE_CONTROL_OFS = 8'h00;
    localparam logic [7:0] PULL_CURRENT_CONTROL_OFS = 8'h04;
    localparam logic [7:0] FILTER_MODE_CONTROL_OFS = 8'h08;
    localparam logic [7:0] WAKE_SOURCE_STATUS_OFS = 8'h0C;
    localparam logic [7:0] ALT_WAKE_SOURCE_STATUS_OFS = 8'h10;
    localparam logic [7:0] PIN_LEVEL_STATUS_OFS = 8'h14;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int MEASURE_PATH_ENABLE_BIT = 3;
    localparam logic [2:0] WAKE_ENABLE_RST = 3'h0;
    localparam logic [5:0] PULL_CURRENT_RST = 6'h00;
    localparam logic [5:0] FILTER_MODE_RST = 6'h00;
    localparam logic [1:0] PULL_NONE = 2'h0;
    localparam logic [1:0] PULL_DOWN = 2'h1;
    localparam logic [1:0] PULL_UP = 2'h2;
    localparam logic [1:0] PULL_AUTO = 2'h3;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 8000;
    localparam int SHORT_FILTER_TIME_US = 16;
    localparam int LONG_FILTER_TIME_US = 64;
    localparam int SHORT_FILTER_CYC =
        (SHORT_FILTER_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int LONG_FILTER_CYC =
        (LONG_FILTER_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int FILTER_CNT_W = 14;

    // ------------------------------------------------------------------
    // Operating modes of the chip, driven in by the mode controller
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_NORMAL,
        MODE_STOP,
        MODE_SLEEP,
        MODE_FAILSAFE,
        MODE_RESTART
    } wid_mode_t;

    // Captured AHB-Lite address phase.
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } wid_aphase_t;

endpackage

// File: wid_filter.sv
// Edge filter for one wake input: a level change must hold for the
// selected number of clock cycles before it is accepted.
// Assumes the level input is already synchronous to clk_i.
`timescale 1ns/100ps
module wid_filter #(
    parameter int SHORT_CYC = wid_pkg::SHORT_FILTER_CYC,
    parameter int LONG_CYC = wid_pkg::LONG_FILTER_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Control
    input wire logic level_i,
    input wire logic eval_i,
    input wire logic long_i,
    input wire logic gate_i,
    // Result
    output logic stable_o,
    output logic event_o
);

    logic [wid_pkg::FILTER_CNT_W-1:0] cnt_q, cnt_d, lim_w;
    logic stable_q, stable_d, event_q, event_d;

    assign lim_w = long_i ? wid_pkg::FILTER_CNT_W'(LONG_CYC - 1) :
                            wid_pkg::FILTER_CNT_W'(SHORT_CYC - 1);

    // ------------------------------------------------------------------
    // Filter counter
    // ------------------------------------------------------------------
    // A gated input tracks the pin silently, so that releasing the gate
    // does not report a stale change as a wake.
    always_comb begin
        cnt_d = cnt_q;
        stable_d = stable_q;
        event_d = 1'b0;
        if (gate_i) begin
            cnt_d = '0;
            stable_d = level_i;
        end else if (!eval_i) begin
            cnt_d = '0;
        end else if (level_i == stable_q) begin
            cnt_d = '0;
        end else if (cnt_q >= lim_w) begin
            stable_d = level_i;
            event_d = 1'b1;
            cnt_d = '0;
        end else begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cnt_q <= '0;
            stable_q <= 1'b0;
            event_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            stable_q <= stable_d;
            event_q <= event_d;
        end
    end

    assign stable_o = stable_q;
    assign event_o = event_q;

    chk_event_held: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        event_q |-> ($past(level_i, 1) == $past(level_i, 2)) &&
                    ($past(level_i, 2) == $past(level_i, 3)))
        else $error("Filter accepted a level that did not hold.");

    chk_gate_quiet: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        gate_i |=> !event_q)
        else $error("Gated input produced a wake event.");

endmodule

// File: wid_top.sv
// Wake input detector: three filtered wake pins, two alternate wake
// inputs, pull-current control, measurement path and AHB-Lite registers.
// Assumes pin levels, mode and timer windows are synchronous to clk_i.
//
// The address map and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/100ps
module wid_top #(
    parameter int LONG_CYC = wid_pkg::LONG_FILTER_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    // Wake pins and alternate wake inputs, comparator levels
    input wire logic [2:0] wake_pin_i,
    input wire logic [1:0] alternate_output_pins_i,
    input wire logic [1:0] alt_wake_cfg_i,
    // Chip state
    input wire logic [2:0] mode_i,
    input wire logic [1:0] cycle_window_i,
    input wire logic sleep_cmd_i,
    // Wake signalling
    output logic wake_irq_o,
    output logic wake_up_o,
    output logic sleep_ok_o,
    output logic spi_fail_o,
    output logic restart_req_o,
    // Analog controls
    output logic [2:0] pull_up_en_o,
    output logic [2:0] pull_dn_en_o,
    output logic measure_path_switch_o
);

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    wid_pkg::wid_aphase_t ap_q, ap_d;
    logic [31:0] rdata_q, rdata_d;
    logic [2:0] en_q, en_d;
    logic meas_q, meas_d;
    logic [5:0] pull_q, pull_d, flt_q, flt_d;
    logic [2:0] src_q, src_d, lvl_q, lvl_d, smp_q, smp_d;
    logic [1:0] alt_q, alt_d;
    logic [2:0] clr_w;
    logic [1:0] alt_clr_w;
    logic [2:0] ev_w, stab_w, gate_w, cyc_w, eval_w, long_w;
    logic [1:0] alt_ev_w;
    logic wr_w, awake_w, asleep_w;

    function automatic logic [31:0] rd_word(input logic [7:0] a,
                                           input logic [2:0] en,
                                           input logic meas,
                                           input logic [5:0] pull,
                                           input logic [5:0] flt,
                                           input logic [2:0] src,
                                           input logic [1:0] alt,
                                           input logic [2:0] lvl);
        logic [31:0] r;
        r = 32'h0;
        case (a)
            wid_pkg::WAKE_ENABLE_CONTROL_OFS: begin
                r[2:0] = en;
                r[wid_pkg::MEASURE_PATH_ENABLE_BIT] = meas;
            end
            wid_pkg::PULL_CURRENT_CONTROL_OFS: r[5:0] = pull;
            wid_pkg::FILTER_MODE_CONTROL_OFS: r[5:0] = flt;
            wid_pkg::WAKE_SOURCE_STATUS_OFS: r[2:0] = src;
            wid_pkg::ALT_WAKE_SOURCE_STATUS_OFS: r[1:0] = alt;
            wid_pkg::PIN_LEVEL_STATUS_OFS: r[2:0] = lvl;
            default: r = 32'h0;
        endcase
        return r;
    endfunction

    // Zero wait states: reads are looked up in the address phase so the
    // data phase can present them from a flip-flop.
    always_comb begin
        ap_d.valid = hsel_i & htrans_i[1] & hready_i;
        ap_d.write = hwrite_i;
        ap_d.addr = haddr_i[7:0];
        rdata_d = rdata_q;
        if (hsel_i & htrans_i[1] & hready_i & !hwrite_i) begin
            rdata_d = rd_word(haddr_i[7:0], en_q, meas_q, pull_q, flt_q,
                              src_q, alt_q, lvl_q);
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ap_q <= '0;
            rdata_q <= 32'h0;
        end else begin
            ap_q <= ap_d;
            rdata_q <= rdata_d;
        end
    end

    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign hrdata_o = rdata_q;
    assign wr_w = ap_q.valid & ap_q.write;
    assign clr_w = (wr_w && ap_q.addr == wid_pkg::WAKE_SOURCE_STATUS_OFS) ?
                   hwdata_i[2:0] : 3'h0;
    assign alt_clr_w =
        (wr_w && ap_q.addr == wid_pkg::ALT_WAKE_SOURCE_STATUS_OFS) ?
        hwdata_i[1:0] : 2'h0;

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    // Settings for gated pins still store; only their effect is masked.
    always_comb begin
        en_d = en_q;
        meas_d = meas_q;
        pull_d = pull_q;
        flt_d = flt_q;
        if (wr_w) begin
            case (ap_q.addr)
                wid_pkg::WAKE_ENABLE_CONTROL_OFS: begin
                    en_d = hwdata_i[2:0];
                    meas_d = hwdata_i[wid_pkg::MEASURE_PATH_ENABLE_BIT];
                end
                wid_pkg::PULL_CURRENT_CONTROL_OFS: pull_d = hwdata_i[5:0];
                wid_pkg::FILTER_MODE_CONTROL_OFS: flt_d = hwdata_i[5:0];
                default: en_d = en_q;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            en_q <= wid_pkg::WAKE_ENABLE_RST;
            meas_q <= 1'b0;
            pull_q <= wid_pkg::PULL_CURRENT_RST;
            flt_q <= wid_pkg::FILTER_MODE_RST;
        end else begin
            en_q <= en_d;
            meas_q <= meas_d;
            pull_q <= pull_d;
            flt_q <= flt_d;
        end
    end

    // ------------------------------------------------------------------
    // Filters
    // ------------------------------------------------------------------
    // Cyclic mode relies on the host powering the pin's circuit from the
    // same timer; outside the window the pin is simply not looked at.
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_pin
            assign gate_w[gi] = (gi < 2) ? meas_q : 1'b0;
            assign cyc_w[gi] = flt_q[2*gi+1];
            assign eval_w[gi] = cyc_w[gi] ?
                cycle_window_i[flt_q[2*gi]] : 1'b1;
            assign long_w[gi] = !flt_q[2*gi+1] & flt_q[2*gi];
            wid_filter #(
                .SHORT_CYC(wid_pkg::SHORT_FILTER_CYC),
                .LONG_CYC(LONG_CYC)
            ) u_filt (
                .clk_i(clk_i),
                .sys_rst_i(sys_rst_i),
                .level_i(wake_pin_i[gi]),
                .eval_i(eval_w[gi]),
                .long_i(long_w[gi]),
                .gate_i(gate_w[gi]),
                .stable_o(stab_w[gi]),
                .event_o(ev_w[gi])
            );
        end
        for (gi = 0; gi < 2; gi++) begin : g_alt
            wid_filter #(
                .SHORT_CYC(wid_pkg::SHORT_FILTER_CYC),
                .LONG_CYC(LONG_CYC)
            ) u_filt (
                .clk_i(clk_i),
                .sys_rst_i(sys_rst_i),
                .level_i(alternate_output_pins_i[gi]),
                .eval_i(1'b1),
                .long_i(1'b0),
                .gate_i(!alt_wake_cfg_i[gi]),
                .stable_o(),
                .event_o(alt_ev_w[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Status, signalling and analog controls
    // ------------------------------------------------------------------
    logic irq_q, irq_d, wku_q, wku_d, ok_q, ok_d, fail_q, fail_d;
    logic sw_q, sw_d;
    logic [2:0] pu_q, pu_d, pd_q, pd_d;
    logic [2:0] qual_w;
    logic [1:0] pm;

    assign awake_w = mode_i == wid_pkg::MODE_NORMAL ||
                     mode_i == wid_pkg::MODE_STOP;
    assign asleep_w = mode_i == wid_pkg::MODE_SLEEP ||
                      mode_i == wid_pkg::MODE_FAILSAFE;
    assign qual_w = ev_w & en_q & ~gate_w;

    always_comb begin
        src_d = (src_q & ~clr_w) | qual_w;
        alt_d = (alt_q & ~alt_clr_w) | alt_ev_w;
        smp_d = smp_q;
        lvl_d = lvl_q;
        pu_d = 3'h0;
        pd_d = 3'h0;
        for (int i = 0; i < 3; i++) begin
            if (cyc_w[i] && eval_w[i]) begin
                smp_d[i] = wake_pin_i[i];
            end
            if (awake_w && !gate_w[i]) begin
                lvl_d[i] = cyc_w[i] ? smp_q[i] : wake_pin_i[i];
            end
            pm = pull_q[2*i +: 2];
            if (!gate_w[i]) begin
                pu_d[i] = pm == wid_pkg::PULL_UP ||
                          (pm == wid_pkg::PULL_AUTO && stab_w[i]);
                pd_d[i] = pm == wid_pkg::PULL_DOWN ||
                          (pm == wid_pkg::PULL_AUTO && !stab_w[i]);
            end
        end
        irq_d = awake_w && (|qual_w || |alt_ev_w);
        wku_d = asleep_w && (|qual_w || |alt_ev_w);
        fail_d = sleep_cmd_i && meas_q && !en_q[2] && |en_q[1:0];
        ok_d = sleep_cmd_i && !fail_d;
        sw_d = meas_q && mode_i == wid_pkg::MODE_NORMAL;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            src_q <= 3'h0;
            alt_q <= 2'h0;
            smp_q <= 3'h0;
            lvl_q <= 3'h0;
            pu_q <= 3'h0;
            pd_q <= 3'h0;
            irq_q <= 1'b0;
            wku_q <= 1'b0;
            fail_q <= 1'b0;
            ok_q <= 1'b0;
            sw_q <= 1'b0;
        end else begin
            src_q <= src_d;
            alt_q <= alt_d;
            smp_q <= smp_d;
            lvl_q <= lvl_d;
            pu_q <= pu_d;
            pd_q <= pd_d;
            irq_q <= irq_d;
            wku_q <= wku_d;
            fail_q <= fail_d;
            ok_q <= ok_d;
            sw_q <= sw_d;
        end
    end

    assign wake_irq_o = irq_q;
    assign wake_up_o = wku_q;
    assign spi_fail_o = fail_q;
    assign restart_req_o = fail_q;
    assign sleep_ok_o = ok_q;
    assign pull_up_en_o = pu_q;
    assign pull_dn_en_o = pd_q;
    assign measure_path_switch_o = sw_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_irq_awake: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        wake_irq_o |-> $past(mode_i) == wid_pkg::MODE_NORMAL ||
                       $past(mode_i) == wid_pkg::MODE_STOP)
        else $error("Wake interrupt outside normal or stop mode.");

    chk_wake_asleep: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        wake_up_o |-> $past(mode_i) == wid_pkg::MODE_SLEEP ||
                      $past(mode_i) == wid_pkg::MODE_FAILSAFE)
        else $error("Wake-up outside sleep or fail-safe mode.");

    chk_flag_sticky: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        1'b1 |=> (src_q & $past(src_q & ~clr_w)) == $past(src_q & ~clr_w))
        else $error("Wake source flag dropped without a clear.");

    chk_flag_enabled: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        1'b1 |=> (src_q & ~$past(src_q) & ~$past(en_q)) == 3'h0)
        else $error("Disabled pin set its wake source flag.");

    chk_meas_pulls: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        meas_q && $past(meas_q) |->
            pull_up_en_o[1:0] == 2'h0 && pull_dn_en_o[1:0] == 2'h0)
        else $error("Pull current active on a gated pin.");

    chk_switch_normal: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        measure_path_switch_o |-> $past(mode_i) == wid_pkg::MODE_NORMAL &&
                                  $past(meas_q))
        else $error("Measurement switch closed outside normal mode.");

    chk_sleep_fail: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        sleep_cmd_i && meas_q && !en_q[2] && en_q[1:0] != 2'h0 |=>
            spi_fail_o && restart_req_o && !sleep_ok_o)
        else $error("Sleep with only gated wake pins was not refused.");

    chk_auto_pull: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        pull_q[5:4] == wid_pkg::PULL_AUTO && stab_w[2] |=>
            pull_up_en_o[2] && !pull_dn_en_o[2])
        else $error("Automatic pull did not follow a high level.");

    chk_level_hold: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        mode_i == wid_pkg::MODE_SLEEP |=> $stable(lvl_q))
        else $error("Level status changed in sleep mode.");

endmodule

// File: wid_wake_src.sv
// Model of the switches and sensors that drive the three wake pins.
// Assumes the bench changes its requests just after a clock edge.
`timescale 1ns/100ps
module wid_wake_src (
    // Clock
    input wire logic clk_i,
    // Bench requests and pull controls
    input wire logic [2:0] drive_en_i,
    input wire logic [2:0] drive_val_i,
    input wire logic [2:0] power_i,
    input wire logic [2:0] pull_up_i,
    input wire logic [2:0] pull_dn_i,
    // Pin levels
    output logic [2:0] pin_o
);
    logic [2:0] wander_q = 3'h0;

    // An open pin with no pull wanders every cycle, so it never settles.
    // A sensor drives its pin only while its high-side supply is on;
    // unpowered, the pin falls to the pull current or wanders.
    always_ff @(posedge clk_i) begin
        wander_q <= ~wander_q;
    end

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            if (drive_en_i[i] && power_i[i]) begin
                pin_o[i] = drive_val_i[i];
            end else if (pull_up_i[i]) begin
                pin_o[i] = 1'b1;
            end else if (pull_dn_i[i]) begin
                pin_o[i] = 1'b0;
            end else begin
                pin_o[i] = wander_q[i];
            end
        end
    end
endmodule

// File: tb.sv
// Self-checking bench for the wake input detector over AHB-Lite.
// The slave inserts no wait states, but every wait is bounded.
`timescale 1ns/100ps
module tb;
    localparam int SH = 2000;
    localparam int LG = 40;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic hresp;
    logic [31:0] hrdata;
    logic [2:0] pin;
    logic [2:0] den = 3'h7;
    logic [2:0] dval = 3'h0;
    logic [1:0] alt = 2'h0;
    logic [1:0] altcfg = 2'h0;
    logic [2:0] mode = 3'h0;
    logic [1:0] win = 2'h0;
    logic slp = 1'b0;
    logic [1:0] hs = 2'h0;
    logic irq, wk, ok, fail, rsr, sw;
    logic [2:0] pup, pdn;
    logic [4:0] pulses;
    logic [4:0] vec;
    int first;
    int mismatches = 0;
    int checked = 0;

    assign pulses = {rsr, fail, ok, wk, irq};
    always #4 clk = ~clk;

    wid_top #(.LONG_CYC(LG)) i_dut (.clk_i(clk), .sys_rst_i(rst),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp),
        .hrdata_o(hrdata), .wake_pin_i(pin),
        .alternate_output_pins_i(alt), .alt_wake_cfg_i(altcfg),
        .mode_i(mode), .cycle_window_i(win), .sleep_cmd_i(slp),
        .wake_irq_o(irq), .wake_up_o(wk), .sleep_ok_o(ok),
        .spi_fail_o(fail), .restart_req_o(rsr), .pull_up_en_o(pup),
        .pull_dn_en_o(pdn), .measure_path_switch_o(sw));

    wid_wake_src i_src (.clk_i(clk), .drive_en_i(den),
        .drive_val_i(dval), .pull_up_i(pup), .pull_dn_i(pdn),
        .power_i({hs == 2'h0 || (hs & win) != 2'h0, 2'h3}), .pin_o(pin));

    task automatic summarize();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // Waits one bus phase; the slave may not stall forever.
    task automatic phase();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (n >= 50) begin
            mismatches++;
            summarize();
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        phase();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        phase();
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r, e);
    endtask

    // Records the first cycle a pulse appears and all pulses then.
    task automatic watch(input int sel, input int lim);
        first = -1;
        vec = 5'h00;
        for (int n = 0; n < lim && first < 0; n++) begin
            @(posedge clk);
            #1;
            if (pulses[sel] === 1'b1) begin
                first = n;
                vec = pulses;
            end
        end
        @(posedge clk);
    endtask

    // A negative expectation means no pulse may appear.
    task automatic hit(input int at);
        if (at < 0) begin
            chk({31'h0, first < 0}, 32'h1);
        end else begin
            chk({31'h0, first >= at - 2 && first <= at + 2}, 32'h1);
        end
    endtask

    task automatic drive(input int i, input logic v);
        @(posedge clk);
        dval[i] <= v;
    endtask

    // Pulses the sleep command and records the outputs one cycle later.
    task automatic sleep_req();
        slp <= 1'b1;
        @(posedge clk);
        slp <= 1'b0;
        #1;
        vec = pulses;
        @(posedge clk);
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a <= 24; a += 4) begin
            rd(8'(a), 32'h0);
        end
        chk({31'h0, hresp}, 32'h0);
        wr(8'h00, 32'h7);
        rd(8'h00, 32'h7);
        for (int c = 0; c < 4; c++) begin
            wr(8'h04, {26'h0, 2'(c), 4'h0});
            repeat (2) @(posedge clk);
            chk({30'h0, pup[2], pdn[2]}, (c == 2) ? 2 : (c == 0) ? 0 : 1);
        end
        drive(2, 1'b1);
        watch(0, SH + 100);
        hit(SH);
        repeat (3) @(posedge clk);
        chk({30'h0, pup[2], pdn[2]}, 32'h2);
        drive(0, 1'b1);
        watch(0, SH + 100);
        hit(SH);
        rd(8'h0C, 32'h5);
        repeat (50) @(posedge clk);
        rd(8'h0C, 32'h5);
        rd(8'h14, 32'h5);
        wr(8'h0C, 32'h7);
        rd(8'h0C, 32'h0);
        drive(0, 1'b0);
        repeat (1000) @(posedge clk);
        drive(0, 1'b1);
        watch(0, SH + 500);
        hit(-1);
        mode <= 3'h1;
        drive(0, 1'b0);
        watch(0, SH + 100);
        hit(SH);
        wr(8'h08, 32'h10);
        drive(2, 1'b0);
        watch(0, LG + 50);
        hit(LG);
        mode <= 3'h2;
        drive(2, 1'b1);
        watch(1, LG + 50);
        hit(LG);
        mode <= 3'h0;
        wr(8'h0C, 32'h7);
        wr(8'h00, 32'h0);
        drive(2, 1'b0);
        watch(0, LG + 50);
        hit(-1);
        wr(8'h00, 32'h4);
        wr(8'h08, 32'h20);
        hs <= 2'h1;
        drive(2, 1'b1);
        watch(0, SH + 500);
        hit(-1);
        rd(8'h14, 32'h0);
        win <= 2'h1;
        watch(0, SH + 100);
        hit(SH);
        rd(8'h14, 32'h4);
        wr(8'h08, 32'h30);
        hs <= 2'h2;
        drive(2, 1'b0);
        win <= 2'h2;
        watch(0, SH + 100);
        hit(SH);
        win <= 2'h0;
        hs <= 2'h0;
        wr(8'h08, 32'h0);
        wr(8'h04, 32'h2A);
        wr(8'h00, 32'hB);
        repeat (3) @(posedge clk);
        chk({29'h0, pup}, 32'h4);
        chk({31'h0, sw}, 32'h1);
        drive(1, 1'b1);
        watch(0, SH + 100);
        hit(-1);
        mode <= 3'h1;
        repeat (3) @(posedge clk);
        chk({31'h0, sw}, 32'h0);
        sleep_req();
        chk({27'h0, vec}, 32'h18);
        wr(8'h00, 32'hF);
        sleep_req();
        chk({27'h0, vec}, 32'h4);
        mode <= 3'h0;
        wr(8'h00, 32'h0);
        altcfg <= 2'h1;
        alt <= 2'h1;
        watch(0, SH + 100);
        hit(SH);
        rd(8'h10, 32'h1);
        summarize();
    end
endmodule
